// >>> design/bkf_top.sv
// backup-domain control and reset-source flag registers on APB.
// assumes: unlock and cause inputs come from pclk logic; oscillator
// ready levels are asynchronous; clock muxing is done downstream.
//
// Overview of operation
// - backup register resets only by backup-domain reset, survives system reset
// - backup register takes byte, half-word and word access by byte lanes
// - crystal, bypass, source and gate writes need backup write unlock
// - bit 16 set holds the backup domain in reset, clear releases
// - bit 15 passes the selected clock to the RTC when set
// - bits 9:8 pick none, slow crystal, internal slow, fast crystal/128
// - a nonzero source locks until the next backup-domain reset
// - bit 2 set bypasses the slow crystal with an external clock
// - bit 0 starts the slow crystal; bit 1 shows it is stable
// - reset value 0x0C000000; flags power-reset only, others system reset
// - bit 31 latches a low-power mode reset
// - bit 30 latches a window watchdog reset
// - bit 29 latches a free watchdog reset
// - bit 28 latches a software reset
// - bit 27 latches a power-on reset
// - bit 26 latches an external pin reset
// - writing 1 to bit 24 clears all six cause flags
// - bit 0 starts the internal slow oscillator; bit 1 shows stable
module bkf_top
    import bkf_pkg::*;
(
    // clock and resets
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  power_rstn,
    input  wire logic                  backup_rstn,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [bkf_pkg::ADDR_W-1:0] paddr,
    input  wire logic [bkf_pkg::DATA_W-1:0] pwdata,
    input  wire logic [bkf_pkg::STRB_W-1:0] pstrb,
    output logic [bkf_pkg::DATA_W-1:0] prdata,
    output logic                       pready,
    output logic                       pslverr,
    // power controller
    input  wire logic                  backup_write_unlock,
    // reset causes, one-cycle or level
    input  wire logic                  cause_low_power,
    input  wire logic                  cause_window_dog,
    input  wire logic                  cause_free_dog,
    input  wire logic                  cause_soft,
    input  wire logic                  cause_pin,
    // oscillator ready levels, asynchronous
    input  wire logic                  slow_crystal_ready,
    input  wire logic                  internal_slow_ready,
    // control outputs
    output logic                       backup_domain_soft_reset,
    output logic                       rtc_clock_gate,
    output logic [1:0]                 rtc_source_select,
    output logic                       slow_crystal_bypass,
    output logic                       slow_crystal_on,
    output logic                       internal_slow_osc_on
);
    import bkf_pkg::*;

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] prdata_reg;
    logic              pready_reg;
    logic              pslverr_reg;
    logic              soft_reset_reg;
    logic              gate_reg;
    logic [1:0]        src_reg;
    logic              bypass_reg;
    logic              xtal_on_reg;
    logic [5:0]        flag_reg;
    logic [5:0]        flag_next;
    logic              clear_reg;
    logic              irc_on_reg;
    logic [1:0]        xtal_sync_reg;
    logic [1:0]        irc_sync_reg;
    logic              xtal_stb;
    logic              irc_stb;
    logic              bkp_rstn;
    logic              setup;
    logic              access;
    logic              sel_bdc;
    logic              sel_rsc;
    logic              wr_bdc;
    logic              wr_rsc;
    logic              wr_locked;
    logic [31:0]       bdc_view;
    logic [31:0]       rsc_view;
    logic [31:0]       bdc_wr;
    logic [31:0]       rsc_wr;
    logic [5:0]        cause_in;

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    assign setup   = psel && !penable;
    assign access  = psel && penable && pready_reg;
    assign sel_bdc = (paddr == BDC_OFS);
    assign sel_rsc = (paddr == RSC_OFS);
    assign wr_bdc  = access && pwrite && sel_bdc;
    assign wr_rsc  = access && pwrite && sel_rsc;
    // locked fields only move when the power controller unlocks them
    assign wr_locked = wr_bdc && backup_write_unlock;

    // merged write words, only written lanes change
    assign bdc_wr = bkf_merge(bdc_view, pwdata, pstrb);
    assign rsc_wr = bkf_merge(rsc_view, pwdata, pstrb);

    // ----------------------------------------------------------------
    // register views
    // ----------------------------------------------------------------
    always_comb begin
        bdc_view = BDC_RESET;
        bdc_view[BDC_SOFT_BIT]                = soft_reset_reg;
        bdc_view[BDC_GATE_BIT]                = gate_reg;
        bdc_view[BDC_SRC_LSB +: 2]            = src_reg;
        bdc_view[BDC_BYP_BIT]                 = bypass_reg;
        bdc_view[BDC_STB_BIT]                 = xtal_stb;
        bdc_view[BDC_ON_BIT]                  = xtal_on_reg;
    end

    always_comb begin
        rsc_view = '0;
        rsc_view[RSC_FLAG_LSB +: RSC_FLAG_N]  = flag_reg;
        rsc_view[RSC_CLR_BIT]                 = clear_reg;
        rsc_view[RSC_STB_BIT]                 = irc_stb;
        rsc_view[RSC_ON_BIT]                  = irc_on_reg;
    end

    // ----------------------------------------------------------------
    // apb answer: ready in the first cycle of the access phase, no wait state
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= '0;
        end else begin
            pready_reg  <= setup;
            if (setup) begin
                pslverr_reg <= !(sel_bdc || sel_rsc);
                if (!pwrite && sel_bdc) begin
                    prdata_reg <= bdc_view;
                end else if (!pwrite && sel_rsc) begin
                    prdata_reg <= rsc_view;
                end else begin
                    prdata_reg <= '0;
                end
            end else if (access) begin
                pslverr_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // backup-domain soft reset bit
    // ----------------------------------------------------------------
    // only the backup-domain reset clears it, never the system reset
    always_ff @(posedge pclk or negedge backup_rstn) begin
        if (!backup_rstn) begin
            soft_reset_reg <= BDC_RESET[BDC_SOFT_BIT];
        end else if (wr_bdc) begin
            soft_reset_reg <= bdc_wr[BDC_SOFT_BIT];
        end
    end

    // backup domain held in reset while the soft bit is set
    assign bkp_rstn = backup_rstn && !soft_reset_reg;

    // ----------------------------------------------------------------
    // backup-domain fields
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge bkp_rstn) begin
        if (!bkp_rstn) begin
            gate_reg    <= BDC_RESET[BDC_GATE_BIT];
            bypass_reg  <= BDC_RESET[BDC_BYP_BIT];
            xtal_on_reg <= BDC_RESET[BDC_ON_BIT];
        end else if (wr_locked) begin
            gate_reg    <= bdc_wr[BDC_GATE_BIT];
            bypass_reg  <= bdc_wr[BDC_BYP_BIT];
            xtal_on_reg <= bdc_wr[BDC_ON_BIT];
        end
    end

    // source select locks once nonzero
    always_ff @(posedge pclk or negedge bkp_rstn) begin
        if (!bkp_rstn) begin
            src_reg <= BDC_RESET[BDC_SRC_LSB +: 2];
        end else if (wr_locked && src_reg == RTC_SRC_NONE) begin
            src_reg <= bdc_wr[BDC_SRC_LSB +: 2];
        end
    end

    // ----------------------------------------------------------------
    // oscillator ready synchronisers and stable flags
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xtal_sync_reg <= '0;
            irc_sync_reg  <= '0;
        end else begin
            xtal_sync_reg <= {xtal_sync_reg[0], slow_crystal_ready};
            irc_sync_reg  <= {irc_sync_reg[0], internal_slow_ready};
        end
    end

    // a flag never shows while its oscillator is off
    assign xtal_stb = xtal_sync_reg[1] && xtal_on_reg;
    assign irc_stb  = irc_sync_reg[1] && irc_on_reg;

    // ----------------------------------------------------------------
    // clear bit and internal oscillator enable, system reset
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clear_reg  <= RSC_RESET[RSC_CLR_BIT];
            irc_on_reg <= RSC_RESET[RSC_ON_BIT];
        end else if (wr_rsc) begin
            clear_reg  <= rsc_wr[RSC_CLR_BIT];
            irc_on_reg <= rsc_wr[RSC_ON_BIT];
        end
    end

    // ----------------------------------------------------------------
    // reset cause flags, power reset only
    // ----------------------------------------------------------------
    always_comb begin
        cause_in           = '0;
        cause_in[FLG_LP]   = cause_low_power;
        cause_in[FLG_WIN]  = cause_window_dog;
        cause_in[FLG_FREE] = cause_free_dog;
        cause_in[FLG_SOFT] = cause_soft;
        cause_in[FLG_PIN]  = cause_pin;
    end

    // a cause arriving with the clear still sets its flag
    always_comb begin
        flag_next = flag_reg;
        if (wr_rsc && rsc_wr[RSC_CLR_BIT]) begin
            flag_next = '0;
        end
        flag_next = flag_next | cause_in;
    end

    // power-on flag comes from the reset value itself
    always_ff @(posedge pclk or negedge power_rstn) begin
        if (!power_rstn) begin
            flag_reg <= FLAG_RESET;
        end else begin
            flag_reg <= flag_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign prdata                   = prdata_reg;
    assign pready                   = pready_reg;
    assign pslverr                  = pslverr_reg;
    assign backup_domain_soft_reset = soft_reset_reg;
    assign rtc_clock_gate           = gate_reg;
    assign rtc_source_select        = src_reg;
    assign slow_crystal_bypass      = bypass_reg;
    assign slow_crystal_on          = xtal_on_reg;
    assign internal_slow_osc_on     = irc_on_reg;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    sequence s_setup;
        psel && !penable;
    endsequence

    sequence s_wr_bdc;
        psel && penable && pready && pwrite && paddr == BDC_OFS;
    endsequence

    sequence s_wr_rsc;
        psel && penable && pready && pwrite && paddr == RSC_OFS;
    endsequence

    // answer comes one cycle after setup
    property p_apb_ready;
        @(posedge pclk) disable iff (!presetn)
        s_setup |=> pready;
    endproperty
    a_apb_ready: assert property (p_apb_ready)
        else $error("pready not high after setup");

    // system reset leaves backup fields untouched
    property p_bdc_keep;
        @(posedge pclk) disable iff (!backup_rstn)
        $fell(presetn) |=> $stable(rtc_source_select) && $stable(rtc_clock_gate);
    endproperty
    a_bdc_keep: assert property (p_bdc_keep)
        else $error("backup field changed on system reset");

    // lane 1 not strobed keeps the clock gate
    property p_lane;
        @(posedge pclk) disable iff (!presetn || !bkp_rstn)
        (s_wr_bdc ##0 !pstrb[1]) |=> $stable(rtc_clock_gate);
    endproperty
    a_lane: assert property (p_lane)
        else $error("unstrobed lane changed");

    // locked write is ignored
    property p_unlock;
        @(posedge pclk) disable iff (!presetn || !bkp_rstn)
        (s_wr_bdc ##0 !backup_write_unlock) |=>
            $stable(slow_crystal_on) && $stable(slow_crystal_bypass);
    endproperty
    a_unlock: assert property (p_unlock)
        else $error("write changed field without unlock");

    // soft reset bit follows the write
    property p_soft;
        @(posedge pclk) disable iff (!backup_rstn)
        (s_wr_bdc ##0 pstrb[2]) |=>
            backup_domain_soft_reset == $past(pwdata[BDC_SOFT_BIT]);
    endproperty
    a_soft: assert property (p_soft)
        else $error("soft reset bit did not follow write");

    // gate follows an unlocked write
    property p_gate;
        @(posedge pclk) disable iff (!presetn || !bkp_rstn)
        (s_wr_bdc ##0 backup_write_unlock && pstrb[1]) |=>
            rtc_clock_gate == $past(pwdata[BDC_GATE_BIT]);
    endproperty
    a_gate: assert property (p_gate)
        else $error("clock gate did not follow write");

    // nonzero source holds
    property p_lock;
        @(posedge pclk) disable iff (!presetn || !bkp_rstn)
        rtc_source_select != RTC_SRC_NONE |=> $stable(rtc_source_select);
    endproperty
    a_lock: assert property (p_lock)
        else $error("locked source select changed");

    // stable flags only with oscillator on
    property p_stb;
        @(posedge pclk) disable iff (!presetn)
        (!slow_crystal_on |-> !xtal_stb) and (!internal_slow_osc_on |-> !irc_stb);
    endproperty
    a_stb: assert property (p_stb)
        else $error("stable flag with oscillator off");

    // window watchdog flag sets and holds
    property p_win;
        @(posedge pclk) disable iff (!power_rstn || !presetn)
        cause_window_dog ##1
            !(psel && penable && pready && pwrite && paddr == RSC_OFS
              && pwdata[RSC_CLR_BIT]) [*2]
            |-> flag_reg[FLG_WIN];
    endproperty
    a_win: assert property (p_win)
        else $error("window watchdog flag lost");

    // clear wipes flags when no cause is present
    property p_clr;
        @(posedge pclk) disable iff (!power_rstn || !presetn)
        (s_wr_rsc ##0 pstrb[3] && pwdata[RSC_CLR_BIT] && cause_in == '0)
            |=> flag_reg == '0;
    endproperty
    a_clr: assert property (p_clr)
        else $error("cause flags not cleared");

endmodule

// >>> design/bkf_pkg.sv
// package: offsets, field positions and reset values of the
// backup-domain control and reset-source registers.
// assumes an APB slave with 8-bit byte address and 32-bit data.
package bkf_pkg;

    // ----------------------------------------------------------------
    // bus geometry
    // ----------------------------------------------------------------
    localparam int          ADDR_W    = 8;
    localparam int          DATA_W    = 32;
    localparam int          STRB_W    = DATA_W / 8;
    localparam logic [7:0]  BDC_OFS   = 8'h20;
    localparam logic [7:0]  RSC_OFS   = 8'h24;

    // ----------------------------------------------------------------
    // backup-domain control register
    // ----------------------------------------------------------------
    localparam logic [31:0] BDC_RESET    = 32'h0000_0018;
    localparam int          BDC_SOFT_BIT = 16;
    localparam int          BDC_GATE_BIT = 15;
    localparam int          BDC_SRC_LSB  = 8;
    localparam int          BDC_BYP_BIT  = 2;
    localparam int          BDC_STB_BIT  = 1;
    localparam int          BDC_ON_BIT   = 0;
    localparam logic [1:0]  RTC_SRC_NONE = 2'h0;
    localparam logic [1:0]  RTC_SRC_SLOW = 2'h1;
    localparam logic [1:0]  RTC_SRC_INT  = 2'h2;
    localparam logic [1:0]  RTC_SRC_FAST = 2'h3;

    // ----------------------------------------------------------------
    // reset-source and internal slow oscillator register
    // ----------------------------------------------------------------
    localparam logic [31:0] RSC_RESET    = 32'h0C00_0000;
    localparam int          RSC_FLAG_LSB = 26;
    localparam int          RSC_FLAG_N   = 6;
    localparam logic [5:0]  FLAG_RESET   = RSC_RESET[31:26];
    localparam int          RSC_CLR_BIT  = 24;
    localparam int          RSC_STB_BIT  = 1;
    localparam int          RSC_ON_BIT   = 0;

    // flag indices inside the six-bit cause vector
    localparam int          FLG_PIN  = 0;
    localparam int          FLG_POR  = 1;
    localparam int          FLG_SOFT = 2;
    localparam int          FLG_FREE = 3;
    localparam int          FLG_WIN  = 4;
    localparam int          FLG_LP   = 5;

    // byte-lane merge of a write into a stored word
    function automatic logic [31:0] bkf_merge(input logic [31:0] old_val,
                                              input logic [31:0] new_val,
                                              input logic [3:0]  strb);
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        return res;
    endfunction

endpackage

// >>> test/bkf_top_tb_top.sv
// testbench for bkf_top: apb access, backup lock, cause flags, oscillators.
// assumes a 250 MHz pclk and that each reset input may be pulsed alone.
module bkf_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import bkf_pkg::*;

    // ----------------------------------------------------------------
    // signals and model state
    // ----------------------------------------------------------------
    logic              pclk, presetn, power_rstn, backup_rstn;
    logic              psel, penable, pwrite, pready, pslverr, unlock, xr, ir;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rd;
    logic [STRB_W-1:0] pstrb;
    logic [5:0]        cz, m_flags;
    logic              soft_o, gate_o, byp_o, on_o, ion_o, er;
    logic [1:0]        src_o, m_src;
    logic              m_on, m_byp, m_gate, m_soft, m_clr, m_ion;
    int                err_count = 0;
    int                n_checks  = 0;

    bkf_top uut (.pclk(pclk), .presetn(presetn), .power_rstn(power_rstn),
        .backup_rstn(backup_rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .backup_write_unlock(unlock),
        .cause_low_power(cz[FLG_LP]), .cause_window_dog(cz[FLG_WIN]),
        .cause_free_dog(cz[FLG_FREE]), .cause_soft(cz[FLG_SOFT]), .cause_pin(cz[FLG_PIN]),
        .slow_crystal_ready(xr), .internal_slow_ready(ir),
        .backup_domain_soft_reset(soft_o), .rtc_clock_gate(gate_o),
        .rtc_source_select(src_o), .slow_crystal_bypass(byp_o),
        .slow_crystal_on(on_o), .internal_slow_osc_on(ion_o));

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // ----------------------------------------------------------------
    // model and bus tasks
    // ----------------------------------------------------------------
    function automatic logic [31:0] exp_bdc();
        return {15'h0000, m_soft, m_gate, 5'h00, m_src, 5'h03, m_byp, m_on & xr, m_on};
    endfunction

    function automatic logic [31:0] exp_rsc();
        return {m_flags, 1'b0, m_clr, 22'h000000, m_ion & ir, m_ion};
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        chk("pready", 32'h1, {31'h0, pready});
    endtask

    task automatic wbdc(input logic [31:0] d, input logic [3:0] s);
        logic held;
        // fields stay in reset at the write edge if the soft bit was already set
        held = m_soft;
        apb(1'b1, BDC_OFS, d, s);
        if (s[2]) m_soft = d[BDC_SOFT_BIT];
        if (unlock && !held && !m_soft && s[0]) begin
            m_on  = d[BDC_ON_BIT];
            m_byp = d[BDC_BYP_BIT];
        end
        if (unlock && !held && !m_soft && s[1]) begin
            m_gate = d[BDC_GATE_BIT];
            if (m_src == RTC_SRC_NONE) m_src = d[9:8];
        end
        if (m_soft) {m_on, m_byp, m_gate, m_src} = 5'h00;
    endtask

    task automatic wrsc(input logic [31:0] d, input logic [3:0] s);
        apb(1'b1, RSC_OFS, d, s);
        if (s[0]) m_ion = d[RSC_ON_BIT];
        if (s[3]) m_clr = d[RSC_CLR_BIT];
        if (s[3] && d[RSC_CLR_BIT]) m_flags = 6'h00;
    endtask

    task automatic rd_both();
        apb(1'b0, BDC_OFS, 32'h0000_0000, 4'hF);
        chk("backup reg", exp_bdc(), rd);
        chk("backup slverr", 32'h0, {31'h0, er});
        apb(1'b0, RSC_OFS, 32'h0000_0000, 4'hF);
        chk("source reg", exp_rsc(), rd);
        chk("source slverr", 32'h0, {31'h0, er});
        chk("outputs", {25'h0, m_soft, m_gate, m_src, m_byp, m_on, m_ion},
            {25'h0, soft_o, gate_o, src_o, byp_o, on_o, ion_o});
    endtask

    // w: bit0 system, bit1 power, bit2 backup
    task automatic rst(input logic [2:0] w);
        if (w[0]) presetn <= 1'b0;
        if (w[1]) power_rstn <= 1'b0;
        if (w[2]) backup_rstn <= 1'b0;
        repeat (12) @(posedge pclk);
        presetn     <= 1'b1;
        power_rstn  <= 1'b1;
        backup_rstn <= 1'b1;
        repeat (3) @(posedge pclk);
        if (w[0]) {m_clr, m_ion} = 2'h0;
        if (w[1]) m_flags = FLAG_RESET;
        if (w[2]) {m_soft, m_on, m_byp, m_gate, m_src} = 6'h00;
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        #(4 * 20000);
        chk("watchdog", 32'h0, 32'h1);
        conclude();
    end

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        {presetn, power_rstn, backup_rstn, psel, penable, pwrite} = 6'h00;
        {paddr, pwdata, pstrb, cz, unlock} = '0;
        xr = 1'b1;
        ir = 1'b1;
        void'($urandom(78498));
        rst(3'h7);
        rd_both();
        wrsc(32'h0100_0000, 4'h8);
        rd_both();
        $display("test reset values done");
        for (int k = 0; k < 6; k++) begin
            if (k != FLG_POR) begin
                @(posedge pclk);
                cz[k] <= 1'b1;
                @(posedge pclk);
                cz[k] <= 1'b0;
                m_flags[k] = 1'b1;
            end
            apb(1'b0, RSC_OFS, 32'h0, 4'hF);
            chk("cause flags", exp_rsc(), rd);
        end
        wrsc(32'h0000_0000, 4'h8);
        rd_both();
        rst(3'h2);
        rd_both();
        wrsc(32'h0100_0000, 4'h8);
        rd_both();
        // a cause held across the clear write must survive it
        cz[FLG_SOFT] <= 1'b1;
        wrsc(32'h0100_0000, 4'h8);
        cz[FLG_SOFT] <= 1'b0;
        m_flags[FLG_SOFT] = 1'b1;
        rd_both();
        $display("test cause flags done");
        wbdc(32'h0000_8305, 4'hF);
        rd_both();
        unlock <= 1'b1;
        wbdc(32'h0000_8105, 4'hF);
        rd_both();
        xr <= 1'b0;
        repeat (4) @(posedge pclk);
        rd_both();
        xr <= 1'b1;
        repeat (4) @(posedge pclk);
        wbdc(32'h0000_0200, 4'h2);
        rd_both();
        wbdc(32'hFFFF_FF00, 4'h1);
        rd_both();
        wbdc(32'h0000_0005, 4'h3);
        rd_both();
        $display("test backup lock done");
        wbdc(32'h0001_0000, 4'h4);
        rd_both();
        wbdc(32'h0000_8105, 4'h3);
        rd_both();
        wbdc(32'h0000_0000, 4'h4);
        wbdc(32'h0000_8301, 4'h3);
        rd_both();
        rst(3'h1);
        rd_both();
        rst(3'h4);
        rd_both();
        $display("test backup resets done");
        wrsc(32'h0000_0001, 4'h1);
        rd_both();
        ir <= 1'b0;
        repeat (4) @(posedge pclk);
        rd_both();
        wrsc(32'h0000_0000, 4'h1);
        ir <= 1'b1;
        repeat (4) @(posedge pclk);
        rd_both();
        apb(1'b1, 8'h2C, 32'hFFFF_FFFF, 4'hF);
        chk("unmapped write err", 32'h1, {31'h0, er});
        apb(1'b0, 8'h28, 32'h0, 4'hF);
        chk("unmapped read", 32'h0000_0000, rd);
        chk("unmapped read err", 32'h1, {31'h0, er});
        rd_both();
        $display("test oscillator and unmapped done");
        for (int i = 0; i < 16; i++) begin
            unlock <= 1'($urandom);
            wbdc($urandom & 32'hFFFE_FFFF, 4'($urandom));
            rd_both();
        end
        $display("test random writes done");
        conclude();
    end
endmodule
